// File: core/sdr_pkg.sv
package sdr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CFG_W       = 8;
  localparam int REF_RATIO_W = 13;
  localparam int REF_SEL_W   = 3;
  localparam int MAIN_W      = 12;
  localparam int SWALLOW_W   = 6;
  localparam int TOTAL_W     = 18;
  localparam int WORD_W      = 24;
  localparam int CNT_W       = 6;

  // ----------------------------------------------------------------
  // Dual-modulus prescaler factor
  // ----------------------------------------------------------------
  localparam int PRESCALE_MOD = 64;

  // ----------------------------------------------------------------
  // Bit counts that select the target of a serial write
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] BITS_LOAD    = 6'h00;
  localparam logic [CNT_W-1:0] BITS_CFG     = 6'h08;
  localparam logic [CNT_W-1:0] BITS_REF     = 6'h10;
  localparam logic [CNT_W-1:0] BITS_SWALLOW = 6'h18;

  // ----------------------------------------------------------------
  // Field positions inside the shifted word
  // ----------------------------------------------------------------
  localparam int REF_RATIO_LSB = 0;
  localparam int REF_SEL_LSB   = 13;
  localparam int SWALLOW_LSB   = 0;
  localparam int MAIN_LSB      = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0]       CFG_RST       = 8'h00;
  localparam logic [REF_RATIO_W-1:0] REF_RATIO_RST = 13'h0001;
  localparam logic [REF_SEL_W-1:0]   REF_SEL_RST   = 3'h0;
  localparam logic [MAIN_W-1:0]      MAIN_RST      = 12'h001;
  localparam logic [SWALLOW_W-1:0]   SWALLOW_RST   = 6'h00;

  // ----------------------------------------------------------------
  // Serial front end states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDR_SH_IDLE   = 2'b00,
    SDR_SH_SHIFT  = 2'b01,
    SDR_SH_COMMIT = 2'b11
  } sdr_shift_e;

endpackage

// File: core/sdr_ser_if.sv
`timescale 1ns/100ps
interface sdr_ser_if;
  logic                      commit;
  logic [sdr_pkg::CNT_W-1:0] bit_count;
  logic [sdr_pkg::WORD_W-1:0] word;
  logic                      sdo;

  modport src (output commit, output bit_count, output word, output sdo);
  modport dst (input commit, input bit_count, input word, input sdo);
endinterface

// File: core/sdr_shift.sv
`timescale 1ns/100ps
module sdr_shift (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Serial pins
  input  wire logic serial_clk,
  input  wire logic serial_data,
  input  wire logic serial_enable_n,
  // To register logic
  sdr_ser_if.src    ser
);

  typedef struct packed {
    sdr_pkg::sdr_shift_e              st;
    logic                             sclk_prev;
    logic [sdr_pkg::WORD_W-1:0]       word;
    logic [sdr_pkg::CNT_W-1:0]        cnt;
  } sdr_shift_s;

  sdr_shift_s q;
  sdr_shift_s d;
  logic       rise;

  assign rise = serial_clk & ~q.sclk_prev;

  always_comb begin
    d = q;
    d.sclk_prev = serial_clk;
    case (q.st)
      sdr_pkg::SDR_SH_IDLE: begin
        if (!serial_enable_n) begin
          d.st  = sdr_pkg::SDR_SH_SHIFT;
          d.cnt = sdr_pkg::BITS_LOAD;
          if (rise) begin
            d.word = {q.word[sdr_pkg::WORD_W-2:0], serial_data};
            d.cnt  = sdr_pkg::BITS_LOAD + 6'h01;
          end
        end
      end
      sdr_pkg::SDR_SH_SHIFT: begin
        // Release of the strobe commits what was counted
        if (serial_enable_n) begin
          d.st = sdr_pkg::SDR_SH_COMMIT;
        end else if (rise) begin
          // Oldest bit leaves at the top for a cascaded device
          d.word = {q.word[sdr_pkg::WORD_W-2:0], serial_data};
          if (q.cnt != '1) begin
            d.cnt = q.cnt + 6'h01;
          end
        end
      end
      sdr_pkg::SDR_SH_COMMIT: begin
        d.st = sdr_pkg::SDR_SH_IDLE;
      end
      default: begin
        d.st = sdr_pkg::SDR_SH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ser.commit    = (q.st == sdr_pkg::SDR_SH_COMMIT);
  assign ser.bit_count = q.cnt;
  assign ser.word      = q.word;
  assign ser.sdo       = q.word[sdr_pkg::WORD_W-1];

endmodule

// File: core/sdr_div.sv
`timescale 1ns/100ps
module sdr_div #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Count input and ratio
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  // Terminal pulse
  output logic              pulse
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } sdr_div_s;

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  sdr_div_s q;
  sdr_div_s d;

  // A new ratio is only taken at the end of the running cycle, so
  // a change never truncates or stretches a cycle already begun
  always_comb begin
    d = q;
    d.pulse = 1'b0;
    if (tick) begin
      if (q.cnt <= ONE) begin
        d.cnt   = ratio;
        d.pulse = 1'b1;
      end else begin
        d.cnt = q.cnt - ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pulse = q.pulse;

endmodule

// File: core/sdr_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Total feedback division is main value times 64 plus swallow value.
// - A swallow write stores new bytes in every cascaded device at once.
// - A swallow write also copies the 13 ratio bits into the active buffer.
// - A swallow write leaves the first reference buffer unchanged.
// - A swallow write leaves the configuration register untouched.
// - A reference write stores and forwards the output select bits at once.
// - A reference write puts the ratio bits only into the first buffer.
// - The reference counter keeps its old ratio until a buffer copy.
// - A bare strobe pulse copies only the first buffer into the active one.
// - A new ratio takes effect only after the current count cycle ends.
module sdr_top (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               nrst,
  // Serial port
  input  wire logic                               serial_clk,
  input  wire logic                               serial_data,
  input  wire logic                               serial_enable_n,
  output logic                                    serial_data_out,
  // Counter inputs
  input  wire logic                               reference_input,
  input  wire logic                               feedback_input,
  // Register contents
  output logic [sdr_pkg::CFG_W-1:0]               config_value,
  output logic [sdr_pkg::REF_SEL_W-1:0]           reference_output_select,
  output logic [sdr_pkg::REF_RATIO_W-1:0]         active_reference_ratio,
  output logic [sdr_pkg::TOTAL_W-1:0]             active_total_ratio,
  // Comparison pulses
  output logic                                    comparison_ref_pulse,
  output logic                                    comparison_fb_pulse
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [sdr_pkg::CFG_W-1:0]       cfg;
    logic [sdr_pkg::REF_RATIO_W-1:0] ref_buf;
    logic [sdr_pkg::REF_RATIO_W-1:0] ref_act;
    logic [sdr_pkg::REF_SEL_W-1:0]   ref_sel;
    logic [sdr_pkg::MAIN_W-1:0]      main_n;
    logic [sdr_pkg::SWALLOW_W-1:0]   swallow;
    logic [sdr_pkg::TOTAL_W-1:0]     total;
    logic                            sdo;
    logic                            ref_prev;
    logic                            fb_prev;
    logic                            ref_pulse;
    logic                            fb_pulse;
  } sdr_top_s;

  function automatic logic [sdr_pkg::TOTAL_W-1:0] total_ratio(
    input logic [sdr_pkg::MAIN_W-1:0]    n,
    input logic [sdr_pkg::SWALLOW_W-1:0] a
  );
    logic [sdr_pkg::TOTAL_W-1:0] t;
    t = sdr_pkg::TOTAL_W'(n) * sdr_pkg::TOTAL_W'(sdr_pkg::PRESCALE_MOD);
    return t + sdr_pkg::TOTAL_W'(a);
  endfunction

  localparam sdr_top_s RST = '{
    cfg:       sdr_pkg::CFG_RST,
    ref_buf:   sdr_pkg::REF_RATIO_RST,
    ref_act:   sdr_pkg::REF_RATIO_RST,
    ref_sel:   sdr_pkg::REF_SEL_RST,
    main_n:    sdr_pkg::MAIN_RST,
    swallow:   sdr_pkg::SWALLOW_RST,
    total:     sdr_pkg::TOTAL_W'(sdr_pkg::MAIN_RST) *
               sdr_pkg::TOTAL_W'(sdr_pkg::PRESCALE_MOD) +
               sdr_pkg::TOTAL_W'(sdr_pkg::SWALLOW_RST),
    sdo:       1'b0,
    ref_prev:  1'b0,
    fb_prev:   1'b0,
    ref_pulse: 1'b0,
    fb_pulse:  1'b0
  };

  sdr_top_s  q;
  sdr_top_s  d;
  sdr_ser_if ser ();
  logic      ref_tick;
  logic      fb_tick;
  logic      ref_div_pulse;
  logic      fb_div_pulse;

  // ----------------------------------------------------------------
  // Serial front end
  // ----------------------------------------------------------------
  sdr_shift u_shift (
    .clk             (clk),
    .nrst            (nrst),
    .serial_clk      (serial_clk),
    .serial_data     (serial_data),
    .serial_enable_n (serial_enable_n),
    .ser             (ser.src)
  );

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  assign ref_tick = reference_input & ~q.ref_prev;
  assign fb_tick  = feedback_input & ~q.fb_prev;

  // Runs on the active buffer only
  sdr_div #(.W(sdr_pkg::REF_RATIO_W)) u_ref_div (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (ref_tick),
    .ratio (q.ref_act),
    .pulse (ref_div_pulse)
  );

  sdr_div #(.W(sdr_pkg::TOTAL_W)) u_fb_div (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (fb_tick),
    .ratio (q.total),
    .pulse (fb_div_pulse)
  );

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.sdo       = ser.sdo;
    d.ref_prev  = reference_input;
    d.fb_prev   = feedback_input;
    d.ref_pulse = ref_div_pulse;
    d.fb_pulse  = fb_div_pulse;
    if (ser.commit) begin
      case (ser.bit_count)
        // Serial clock held low, so no bits were counted
        sdr_pkg::BITS_LOAD: begin
          d.ref_act = q.ref_buf;
        end
        sdr_pkg::BITS_CFG: begin
          d.cfg = ser.word[sdr_pkg::CFG_W-1:0];
        end
        sdr_pkg::BITS_REF: begin
          d.ref_sel = ser.word[sdr_pkg::REF_SEL_LSB +:
                               sdr_pkg::REF_SEL_W];
          d.ref_buf = ser.word[sdr_pkg::REF_RATIO_LSB +:
                               sdr_pkg::REF_RATIO_W];
        end
        sdr_pkg::BITS_SWALLOW: begin
          // Every device sees the same release edge
          d.swallow = ser.word[sdr_pkg::SWALLOW_LSB +:
                               sdr_pkg::SWALLOW_W];
          d.main_n  = ser.word[sdr_pkg::MAIN_LSB +:
                               sdr_pkg::MAIN_W];
          d.total   = total_ratio(
                        ser.word[sdr_pkg::MAIN_LSB +: sdr_pkg::MAIN_W],
                        ser.word[sdr_pkg::SWALLOW_LSB +:
                                 sdr_pkg::SWALLOW_W]);
          d.ref_act = q.ref_buf;
        end
        default: begin
          // Unknown lengths change nothing
          d.cfg = q.cfg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_data_out         = q.sdo;
  assign config_value            = q.cfg;
  assign reference_output_select = q.ref_sel;
  assign active_reference_ratio  = q.ref_act;
  assign active_total_ratio      = q.total;
  assign comparison_ref_pulse    = q.ref_pulse;
  assign comparison_fb_pulse     = q.fb_pulse;

endmodule

// File: sim/sdr_top_monitor.sv
`timescale 1ns/100ps
module sdr_top_monitor (
  // Clock and reset
  input wire logic                              clk,
  input wire logic                              nrst,
  // Serial port
  input wire logic                              serial_enable_n,
  input wire logic                              serial_data_out,
  // Counter inputs
  input wire logic                              reference_input,
  input wire logic                              feedback_input,
  // Register contents
  input wire logic [sdr_pkg::CFG_W-1:0]         config_value,
  input wire logic [sdr_pkg::REF_SEL_W-1:0]     reference_output_select,
  input wire logic [sdr_pkg::REF_RATIO_W-1:0]   active_reference_ratio,
  input wire logic [sdr_pkg::TOTAL_W-1:0]       active_total_ratio,
  // Comparison pulses
  input wire logic                              comparison_ref_pulse,
  input wire logic                              comparison_fb_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Strobe history; commit lands two edges after release is seen
  logic [2:0] en_hist_q;
  logic       commit_seen;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) en_hist_q <= 3'h7;
    else en_hist_q <= {en_hist_q[1:0], serial_enable_n};
  end
  assign commit_seen = en_hist_q[1] & ~en_hist_q[2];

  property p_cfg_commit; $changed(config_value) |-> commit_seen; endproperty
  a_cfg_commit: assert property (p_cfg_commit)
    else $error("config moved outside a commit");
  property p_sel_commit;
    $changed(reference_output_select) |-> commit_seen;
  endproperty
  a_sel_commit: assert property (p_sel_commit)
    else $error("select moved outside a commit");
  property p_act_commit;
    $changed(active_reference_ratio) |-> commit_seen;
  endproperty
  a_act_commit: assert property (p_act_commit)
    else $error("active ratio moved outside a commit");
  property p_tot_commit;
    $changed(active_total_ratio) |-> commit_seen;
  endproperty
  a_tot_commit: assert property (p_tot_commit)
    else $error("total ratio moved outside a commit");
  property p_tot_cfg;
    $changed(active_total_ratio) |-> $stable(config_value);
  endproperty
  a_tot_cfg: assert property (p_tot_cfg)
    else $error("swallow write touched config");
  property p_sel_act;
    $changed(reference_output_select) |-> $stable(active_reference_ratio);
  endproperty
  a_sel_act: assert property (p_sel_act)
    else $error("reference write moved active ratio");
  property p_act_sel;
    $changed(active_reference_ratio) |-> $stable(reference_output_select);
  endproperty
  a_act_sel: assert property (p_act_sel)
    else $error("buffer copy touched select");
  property p_ref_pulse;
    comparison_ref_pulse |-> $past(reference_input, 2)
      && !$past(reference_input, 3);
  endproperty
  a_ref_pulse: assert property (p_ref_pulse)
    else $error("ref pulse without input edge");
  property p_fb_pulse;
    comparison_fb_pulse |-> $past(feedback_input, 2)
      && !$past(feedback_input, 3);
  endproperty
  a_fb_pulse: assert property (p_fb_pulse)
    else $error("fb pulse without input edge");
  property p_sdo_idle; serial_enable_n [*5] |-> $stable(serial_data_out);
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("cascade out moved while idle");
endmodule

bind sdr_top sdr_top_monitor sdr_top_monitor_inst (
  .clk(clk), .nrst(nrst), .serial_enable_n(serial_enable_n),
  .serial_data_out(serial_data_out), .reference_input(reference_input),
  .feedback_input(feedback_input), .config_value(config_value),
  .reference_output_select(reference_output_select),
  .active_reference_ratio(active_reference_ratio),
  .active_total_ratio(active_total_ratio),
  .comparison_ref_pulse(comparison_ref_pulse),
  .comparison_fb_pulse(comparison_fb_pulse));

// File: sim/sdr_host_model.sv
`timescale 1ns/100ps
module sdr_host_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      serial_clk,
  output logic      serial_data,
  output logic      serial_enable_n
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    serial_enable_n = 1'b1;
  end

  // Low n bits of w, MSB first; n of 0 is the bare load pulse
  task automatic xfer(input logic [23:0] w, input int n);
    int i;
    @(posedge clk);
    serial_enable_n <= 1'b0;
    serial_clk <= 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      serial_data <= w[i];
      @(posedge clk);
      serial_clk <= 1'b1;
      @(posedge clk);
      serial_clk <= 1'b0;
    end
    @(posedge clk);
    serial_enable_n <= 1'b1;
    // Released line must not keep a usable level
    serial_data <= ~serial_data;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
endmodule

// File: sim/sdr_top_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    error_cnt++; \
    $display("wrong value %s exp %0h got %0h", n, e, a); \
  end \
end
module sdr_top_tb;
  logic clk, nrst, reference_input, feedback_input;
  logic serial_clk, serial_data, serial_enable_n, serial_data_out;
  logic [sdr_pkg::CFG_W-1:0]       config_value;
  logic [sdr_pkg::REF_SEL_W-1:0]   reference_output_select;
  logic [sdr_pkg::REF_RATIO_W-1:0] active_reference_ratio;
  logic [sdr_pkg::TOTAL_W-1:0]     active_total_ratio;
  logic comparison_ref_pulse, comparison_fb_pulse;
  logic [1:0] ph_q = 2'h0;
  int error_cnt, cmp_count;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Reference edges every 4 clk, feedback edges every 2 clk
  always @(posedge clk) begin
    ph_q <= ph_q + 2'h1;
    reference_input <= ph_q[1];
    feedback_input <= ph_q[0];
  end

  sdr_host_model sdr_host_model_inst (.clk(clk), .serial_clk(serial_clk),
    .serial_data(serial_data), .serial_enable_n(serial_enable_n));
  sdr_top sdr_top_inst (.clk(clk), .nrst(nrst), .serial_clk(serial_clk),
    .serial_data(serial_data), .serial_enable_n(serial_enable_n),
    .serial_data_out(serial_data_out), .reference_input(reference_input),
    .feedback_input(feedback_input), .config_value(config_value),
    .reference_output_select(reference_output_select),
    .active_reference_ratio(active_reference_ratio),
    .active_total_ratio(active_total_ratio),
    .comparison_ref_pulse(comparison_ref_pulse),
    .comparison_fb_pulse(comparison_fb_pulse));

  task automatic give_verdict;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cycles from the current pulse to the next one
  task automatic gap(input bit fb, output int n);
    for (n = 1; n < 2000; n++) begin
      @(negedge clk);
      if ((fb ? comparison_fb_pulse : comparison_ref_pulse) === 1'b1) break;
    end
  endtask
  task automatic sync(input bit fb);
    int n;
    gap(fb, n);
  endtask
  task automatic t_reset;
    int n;
    `CHK("config", 8'h00, config_value);
    `CHK("active", 13'h0001, active_reference_ratio);
    `CHK("total", 18'h00040, active_total_ratio);
    sync(1'b1);
    gap(1'b1, n);
    `CHK("fb gap", 128, n);
  endtask
  task automatic t_cfg;
    sdr_host_model_inst.xfer(24'h0000A5, 8);
    `CHK("config", 8'hA5, config_value);
    `CHK("select", 3'h0, reference_output_select);
  endtask
  task automatic t_ref;
    int n;
    // Ratio 5 for a 4 clk reference, select 5
    sdr_host_model_inst.xfer(24'h00A005, 16);
    `CHK("select", 3'h5, reference_output_select);
    `CHK("active", 13'h0001, active_reference_ratio);
    sync(1'b0);
    gap(1'b0, n);
    `CHK("ref gap", 4, n);
  endtask
  task automatic t_load;
    sdr_host_model_inst.xfer(24'h000000, 0);
    `CHK("active", 13'h0005, active_reference_ratio);
    `CHK("config", 8'hA5, config_value);
    `CHK("select", 3'h5, reference_output_select);
  endtask
  task automatic t_finish_cycle;
    int n;
    sdr_host_model_inst.xfer(24'h004003, 16);
    sync(1'b0);
    fork
      sdr_host_model_inst.xfer(24'h000000, 0);
      gap(1'b0, n);
    join
    `CHK("old gap", 20, n);
    gap(1'b0, n);
    `CHK("new gap", 12, n);
  endtask
  task automatic t_swallow;
    int n;
    sdr_host_model_inst.xfer(24'h000007, 16);
    sdr_host_model_inst.xfer(24'h800083, 24);
    `CHK("active", 13'h0007, active_reference_ratio);
    `CHK("total", 18'h00083, active_total_ratio);
    `CHK("config", 8'hA5, config_value);
    `CHK("cascade", 1'b1, serial_data_out);
    sync(1'b1);
    gap(1'b1, n);
    `CHK("fb gap", 262, n);
    sdr_host_model_inst.xfer(24'h000000, 0);
    `CHK("active", 13'h0007, active_reference_ratio);
  endtask
  task automatic t_refused;
    sdr_host_model_inst.xfer(24'h000FFF, 12);
    `CHK("config", 8'hA5, config_value);
    `CHK("select", 3'h0, reference_output_select);
    `CHK("active", 13'h0007, active_reference_ratio);
  endtask

  initial begin
    nrst = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    t_reset;
    t_cfg;
    t_ref;
    t_load;
    t_finish_cycle;
    t_swallow;
    t_refused;
    give_verdict;
  end
  // Tests need about a thousand cycles; 20000 means a hang
  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end
endmodule
